// ### shared/ibr_pkg.sv
// Constants for the two-wire bit-rate generator and boot reader
// Behaviour
// R1: Bit clock is platform clock, prescaled, then divided
// R2: Codes 0x00-0x0F pick divisors 384 to 3840
// R3: Codes 0x10-0x1F pick divisors 4608 to 61440
// R4: Codes 0x20-0x2A pick divisors 256 to 896
// R5: Codes 0x2B-0x3F pick divisors 1024 to 32768
// R6: First data register read is a dummy
// R7: Boot strap makes controller read EEPROM configuration
// R8: Boot accesses use platform clock divided by 3840
// R9: Divider code resets to zero, writable any time
package ibr_pkg;

  // ****************************************************************
  // Register map, word aligned byte addresses
  // ****************************************************************
  localparam logic [7:0] IBR_DIV_OFS  = 8'h00;
  localparam logic [7:0] IBR_CTL_OFS  = 8'h04;
  localparam logic [7:0] IBR_STAT_OFS = 8'h08;
  localparam logic [7:0] IBR_DATA_OFS = 8'h0C;

  // Field positions and reset values
  localparam int          IBR_CTL_GO     = 0;
  localparam int          IBR_STAT_BUSY  = 0;
  localparam int          IBR_STAT_BOOT  = 1;
  localparam int          IBR_STAT_NACK  = 2;
  localparam logic [5:0]  IBR_DIV_RST    = 6'h00;
  localparam logic [6:0]  IBR_ADDR_RST   = 7'h00;
  localparam logic [7:0]  IBR_DATA_RST   = 8'h00;

  // ****************************************************************
  // Clock division
  // ****************************************************************
  localparam logic [1:0]  IBR_PRE_THIRD  = 2'h3;
  localparam logic [1:0]  IBR_PRE_HALF   = 2'h2;
  localparam logic [15:0] IBR_BOOT_DIV   = 16'hF00;
  localparam logic [15:0] IBR_BOOT_QTR   = IBR_BOOT_DIV >> 2;
  localparam logic [1:0]  IBR_BOOT_MODE  = 2'h2;

  // Divisor per 6-bit code
  localparam logic [15:0] IBR_DIV_TABLE [0:63] = '{
    16'h0180, 16'h01A0, 16'h01E0, 16'h0240, 16'h0280, 16'h02C0,
    16'h0340, 16'h0400, 16'h0480, 16'h0500, 16'h0600, 16'h0780,
    16'h0900, 16'h0A00, 16'h0C00, 16'h0F00,
    16'h1200, 16'h1400, 16'h1800, 16'h1E00, 16'h2400, 16'h2800,
    16'h3000, 16'h3C00, 16'h4800, 16'h5000, 16'h6000, 16'h7800,
    16'h9000, 16'hA000, 16'hC000, 16'hF000,
    16'h0100, 16'h0120, 16'h0140, 16'h0160, 16'h0180, 16'h01C0,
    16'h0200, 16'h0240, 16'h0280, 16'h0300, 16'h0380,
    16'h0400, 16'h0500, 16'h0600, 16'h0700, 16'h0800, 16'h0A00,
    16'h0C00, 16'h0E00, 16'h1000, 16'h1400, 16'h1800, 16'h1C00,
    16'h2000, 16'h2800, 16'h3000, 16'h3800, 16'h4000, 16'h5000,
    16'h6000, 16'h7000, 16'h8000
  };

  // Transfer sequencer states
  typedef enum logic [1:0] {
    IBR_IDLE,
    IBR_START,
    IBR_BITS,
    IBR_STOP
  } ibr_state_e;

endpackage

// ### verilog/ibr_core.sv
// Two-wire bit-rate generator, byte reader and boot EEPROM reader
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module ibr_core
#(
  parameter int         BOOT_BYTES = 4,
  parameter logic [6:0] BOOT_ADDR  = 7'h50
)
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    sec_ratio_strap_i,
  input  wire logic [1:0]              boot_seq_strap_i,
  input  wire logic                    first_bus_clock_pin_i,
  output logic                         first_bus_clock_pin_o,
  output logic                         first_bus_clock_pin_oe_o,
  input  wire logic                    first_bus_data_pin_i,
  output logic                         first_bus_data_pin_o,
  output logic                         first_bus_data_pin_oe_o,
  output logic      [BOOT_BYTES*8-1:0] boot_cfg_o,
  output logic                         boot_done_o
);
  import ibr_pkg::*;

  // Sizes and state shared by the processes below
  localparam int CFG_W = BOOT_BYTES * 8;
  logic        strap_taken, third_sel, boot_kick, boot_done_o_q;
  logic        go, nack_clr, nack, nack_evt, pre_tick, qtick;
  logic        addr_phase, ack_bit, boot_act, sw_pend, req;
  logic [1:0]  pre_cnt, pre_max, q;
  logic [3:0]  bit_cnt;
  logic [5:0]  div_code;
  logic [6:0]  slave_addr;
  logic [7:0]  rx_byte, rd_hold, rx_sh, bytes_left;
  logic [8:0]  tx_sh;
  logic [15:0] quarter, div_cnt;
  ibr_state_e  state;

  // Pins are open drain: only ever pull low
  assign first_bus_clock_pin_o = 1'b0;
  assign first_bus_data_pin_o  = 1'b0;
  assign boot_done_o           = boot_done_o_q;

  // ****************************************************************
  // Strap capture and bit-rate generation
  // ****************************************************************
  // Straps caught once, on the first edge after reset release
  always_ff @(posedge clk_i)
  begin
    strap_taken <= !rst_i;
    boot_kick   <= !rst_i && !strap_taken
                   && (boot_seq_strap_i == IBR_BOOT_MODE); // see R7
    if (rst_i)
      third_sel <= 1'b1;
    else if (!strap_taken)
      third_sel <= sec_ratio_strap_i; // see R1
  end

  // Boot uses a fixed divider, ignoring software and prescale
  always_comb
  begin
    pre_max = third_sel ? IBR_PRE_THIRD : IBR_PRE_HALF; // see R1
    quarter = boot_act ? IBR_BOOT_QTR                   // see R8
                       : (IBR_DIV_TABLE[div_code] >> 2); // see R2 R3 R4 R5
    pre_tick = boot_act || (pre_cnt >= pre_max - 2'h1);
    qtick    = pre_tick && (div_cnt >= quarter - 16'h0001);
  end

  // Prescaler by three or two
  always_ff @(posedge clk_i)
  begin
    if (rst_i || pre_tick)
      pre_cnt <= 2'h0;
    else
      pre_cnt <= pre_cnt + 2'h1; // see R1
  end

  // Quarter-bit counter; >= compare lets a smaller code act at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i || qtick)
      div_cnt <= 16'h0000;
    else if (pre_tick)
      div_cnt <= div_cnt + 16'h0001; // see R1 R9
  end

  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  // Start, address, data bytes with ack, stop; one step per quarter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state                    <= IBR_IDLE;
      q                        <= 2'h0;
      bit_cnt                  <= 4'h0;
      tx_sh                    <= 9'h1FF;
      rx_sh                    <= 8'h00;
      rx_byte                  <= IBR_DATA_RST;
      bytes_left               <= 8'h00;
      addr_phase               <= 1'b0;
      ack_bit                  <= 1'b0;
      boot_act                 <= 1'b0;
      boot_done_o_q            <= 1'b0;
      sw_pend                  <= 1'b0;
      nack_evt                 <= 1'b0;
      boot_cfg_o               <= '0;
      first_bus_clock_pin_oe_o <= 1'b0;
      first_bus_data_pin_oe_o  <= 1'b0;
    end
    else
    begin
      nack_evt <= 1'b0;
      if (boot_kick)
        boot_act <= 1'b1; // see R7
      if (go)
        sw_pend <= 1'b1;
      if (qtick)
      begin
        case (state)
          IBR_IDLE:
          begin
            first_bus_clock_pin_oe_o <= 1'b0;
            first_bus_data_pin_oe_o  <= 1'b0;
            if (boot_act || sw_pend)
            begin
              // Boot reads its whole image, software one byte
              tx_sh      <= {boot_act ? BOOT_ADDR : slave_addr, 2'b11};
              bytes_left <= boot_act ? 8'(BOOT_BYTES) : 8'h01;
              addr_phase <= 1'b1;
              sw_pend    <= boot_act ? sw_pend : 1'b0;
              q          <= 2'h0;
              state      <= IBR_START;
            end
          end
          IBR_START:
          begin
            q <= q + 2'h1;
            if (q == 2'h0)
              first_bus_data_pin_oe_o <= 1'b1;
            else
            begin
              first_bus_clock_pin_oe_o <= 1'b1;
              bit_cnt                  <= 4'h0;
              q                        <= 2'h0;
              state                    <= IBR_BITS;
            end
          end
          IBR_BITS:
          begin
            q <= q + 2'h1;
            case (q)
              2'h0: first_bus_data_pin_oe_o  <= ~tx_sh[8];
              2'h1: first_bus_clock_pin_oe_o <= 1'b0;
              2'h2:
              begin
                if (bit_cnt == 4'h8)
                  ack_bit <= first_bus_data_pin_i;
                else
                  rx_sh <= {rx_sh[6:0], first_bus_data_pin_i};
              end
              default:
              begin
                first_bus_clock_pin_oe_o <= 1'b1;
                tx_sh                    <= {tx_sh[7:0], 1'b1};
                bit_cnt                  <= bit_cnt + 4'h1;
                if (bit_cnt == 4'h8)
                begin
                  bit_cnt <= 4'h0;
                  if (addr_phase)
                  begin
                    addr_phase <= 1'b0;
                    tx_sh      <= {8'hFF, bytes_left == 8'h01};
                    if (ack_bit)
                    begin
                      nack_evt <= 1'b1;
                      state    <= IBR_STOP;
                    end
                  end
                  else
                  begin
                    rx_byte    <= rx_sh;
                    bytes_left <= bytes_left - 8'h01;
                    tx_sh      <= {8'hFF, bytes_left == 8'h02};
                    if (boot_act)
                      boot_cfg_o <= CFG_W'({boot_cfg_o, rx_sh});
                    if (bytes_left == 8'h01)
                      state <= IBR_STOP;
                  end
                end
              end
            endcase
          end
          IBR_STOP:
          begin
            q <= q + 2'h1;
            case (q)
              2'h0: first_bus_data_pin_oe_o  <= 1'b1;
              2'h1: first_bus_clock_pin_oe_o <= 1'b0;
              2'h2: first_bus_data_pin_oe_o  <= 1'b0;
              default:
              begin
                state <= IBR_IDLE;
                if (boot_act)
                begin
                  boot_act      <= 1'b0;
                  boot_done_o_q <= 1'b1;
                end
              end
            endcase
          end
          default: state <= IBR_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      if (req)
      begin
        case ({wb_adr_i[7:2], 2'b00})
          IBR_DIV_OFS:  wb_dat_o <= {26'h0, div_code};
          IBR_CTL_OFS:  wb_dat_o <= {24'h0, slave_addr, sw_pend};
          IBR_STAT_OFS: wb_dat_o <= {29'h0, nack, boot_done_o_q,
                                     state != IBR_IDLE};
          IBR_DATA_OFS: wb_dat_o <= {24'h0, rd_hold}; // see R6
          default:      wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writes land on the acknowledging edge, low byte lane only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_code   <= IBR_DIV_RST; // see R9
      slave_addr <= IBR_ADDR_RST;
      go         <= 1'b0;
      nack_clr   <= 1'b0;
    end
    else
    begin
      go       <= 1'b0;
      nack_clr <= 1'b0;
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0])
      begin
        case ({wb_adr_i[7:2], 2'b00})
          IBR_DIV_OFS: div_code <= wb_dat_i[5:0]; // see R9
          IBR_CTL_OFS:
          begin
            slave_addr <= wb_dat_i[7:1];
            go         <= wb_dat_i[IBR_CTL_GO];
          end
          IBR_STAT_OFS: nack_clr <= wb_dat_i[IBR_STAT_NACK];
          default: ;
        endcase
      end
    end
  end

  // Data reads return the byte held from the previous read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_hold <= IBR_DATA_RST;
    else if (wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i
             && {wb_adr_i[7:2], 2'b00} == IBR_DATA_OFS)
      rd_hold <= rx_byte; // see R6
  end

  // Address nack is sticky; a fresh nack beats the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      nack <= 1'b0;
    else if (nack_evt)
      nack <= 1'b1;
    else if (nack_clr)
      nack <= 1'b0;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [16:0] gap, expect_gap, expect_q;
  logic        gap_ok, first_rd;
  assign expect_gap = boot_act ? {1'b0, quarter} : 17'(pre_max * quarter);

  // Helper: cycles between quarter ticks with a stable setting
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gap      <= 17'h00001;
      gap_ok   <= 1'b0;
      expect_q <= 17'h00000;
      first_rd <= 1'b1;
    end
    else
    begin
      expect_q <= expect_gap;
      gap      <= qtick ? 17'h00001 : gap + 17'h00001;
      if (qtick)
        gap_ok <= 1'b1;
      else if (expect_gap != expect_q)
        gap_ok <= 1'b0;
      if (wb_ack_o && !wb_we_i && {wb_adr_i[7:2], 2'b00} == IBR_DATA_OFS)
        first_rd <= 1'b0;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  quarter_gap_a: assert property ( // see R1
    (qtick && gap_ok && !boot_act && expect_gap == expect_q)
      |-> gap == expect_gap)
    else $error("Quarter period differs from prescale times divisor");
  code_low_a: assert property ( // see R2
    (!boot_act && div_code == 6'h00) |-> quarter == 16'h0060)
    else $error("Code 0x00 does not divide by 384");
  code_mid_a: assert property ( // see R3
    (!boot_act && div_code == 6'h1F) |-> quarter == 16'h3C00)
    else $error("Code 0x1F does not divide by 61440");
  code_alt_a: assert property ( // see R4
    (!boot_act && div_code == 6'h20) |-> quarter == 16'h0040)
    else $error("Code 0x20 does not divide by 256");
  code_top_a: assert property ( // see R5
    (!boot_act && div_code == 6'h3F) |-> quarter == 16'h2000)
    else $error("Code 0x3F does not divide by 32768");
  dummy_read_a: assert property ( // see R6
    (wb_ack_o && !wb_we_i && first_rd
     && {wb_adr_i[7:2], 2'b00} == IBR_DATA_OFS) |-> wb_dat_o[7:0] == 8'h00)
    else $error("First data read is not the dummy value");
  boot_start_a: assert property ( // see R7
    boot_kick |=> boot_act ##[1:1000] state == IBR_START)
    else $error("Boot strap did not start an EEPROM read");
  boot_rate_a: assert property ( // see R8
    (qtick && gap_ok && boot_act && $past(boot_act)) |-> gap == 17'h003C0)
    else $error("Boot quarter period is not 960 cycles");
  div_write_a: assert property ( // see R9
    (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
     && {wb_adr_i[7:2], 2'b00} == IBR_DIV_OFS)
      |=> div_code == $past(wb_dat_i[5:0]))
    else $error("Divider code write did not take");
  bus_ack_a: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus answer is not a single cycle after request");

  boot_done_c: cover property ($rose(boot_done_o_q));
  sw_byte_c:   cover property (qtick && state == IBR_STOP && !boot_act);
  nack_c:      cover property (nack_evt);

endmodule

// ### test/ibr_eeprom.sv
// Behavioural serial EEPROM answering current-address reads
`timescale 1ns/1ps
module ibr_eeprom
#(
  parameter logic [6:0] DEV_ADDR   = 7'h50,
  parameter logic [7:0] FIRST_BYTE = 8'hA5
)
(
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_oe_o
);
  logic [7:0] shift_in;
  logic [7:0] next_byte;
  logic       active;
  logic       reading;
  int         bit_cnt;

  // ****************************************************************
  // Frame tracking
  // ****************************************************************
  // Idle and released at time zero
  initial
  begin
    sda_oe_o  = 1'b0;
    active    = 1'b0;
    reading   = 1'b0;
    bit_cnt   = 0;
    shift_in  = 8'h00;
    next_byte = FIRST_BYTE;
  end

  // Start and stop are data edges while the clock is high
  always @(sda_i)
  begin
    if (scl_i === 1'b1)
    begin
      active   = !sda_i;
      reading  = 1'b0;
      bit_cnt  = 0;
      sda_oe_o = 1'b0;
    end
  end

  // Sample address bits and the master's ack on the rising clock
  always @(posedge scl_i)
  begin
    if (active && !reading && bit_cnt < 8)
      shift_in = {shift_in[6:0], sda_i};
    if (active && reading && bit_cnt == 8)
    begin
      next_byte = next_byte + 8'h01;
      active    = !sda_i;
    end
    bit_cnt = bit_cnt + 1;
  end

  // Change the line only with the clock low, so no false start or stop
  always @(negedge scl_i)
  begin
    if (bit_cnt == 9)
    begin
      bit_cnt = 0;
      reading = active;
    end
    if (!active)
      sda_oe_o = 1'b0;
    else if (!reading && bit_cnt == 8)
    begin
      sda_oe_o = (shift_in == {DEV_ADDR, 1'b1});
      active   = sda_oe_o;
    end
    else if (reading && bit_cnt < 8)
      sda_oe_o = ~next_byte[3'(7 - bit_cnt)];
    else
      sda_oe_o = 1'b0;
  end
endmodule

// ### test/tb_top.sv
// Self-checking bench for the bit-rate generator and boot reader
`timescale 1ns/1ps
`define IBR_CHK(act, exp) \
  begin \
    tests_run++; \
    if ((act) !== (exp)) \
    begin \
      fail_count++; \
      $display("[FAIL] t=%0t got %0h expected %0h", $time, act, exp); \
    end \
  end
module tb_top;
  import ibr_pkg::*;

  localparam int         LIMIT       = 125000;
  localparam logic [5:0] CODES   [3] = '{6'h2B, 6'h2A, 6'h20};
  localparam int         DIVS    [3] = '{1024, 896, 256};
  localparam int         PRES    [3] = '{2, 2, 3};
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        cyc    = 1'b0;
  logic        stb    = 1'b0;
  logic        we     = 1'b0;
  logic [7:0]  adr    = 8'h00;
  logic [3:0]  sel    = 4'h0;
  logic [31:0] dat_w  = 32'h0;
  logic        sec    = 1'b1;
  logic [1:0]  boot   = 2'b00;
  logic [31:0] dat_r;
  logic [31:0] rd_q;
  logic        ack;
  logic        scl_oe;
  logic        sda_oe;
  logic        ee_oe;
  logic [7:0]  boot_cfg;
  logic        boot_done;
  wire logic   scl    = !scl_oe;
  wire logic   sda    = !(sda_oe | ee_oe);
  int          fail_count = 0;
  int          tests_run  = 0;
  int          cycles     = 0;
  int          period;

  // ****************************************************************
  // Design and far side
  // ****************************************************************
  // Lines resolve as open drain with a pull-up
  ibr_core
  #(
    .BOOT_BYTES (1),
    .BOOT_ADDR  (7'h50)
  )
  DUT
  (
    .clk_i                    (clk),
    .rst_i                    (rst),
    .wb_cyc_i                 (cyc),
    .wb_stb_i                 (stb),
    .wb_we_i                  (we),
    .wb_adr_i                 (adr),
    .wb_sel_i                 (sel),
    .wb_dat_i                 (dat_w),
    .wb_dat_o                 (dat_r),
    .wb_ack_o                 (ack),
    .sec_ratio_strap_i        (sec),
    .boot_seq_strap_i         (boot),
    .first_bus_clock_pin_i    (scl),
    .first_bus_clock_pin_o    (),
    .first_bus_clock_pin_oe_o (scl_oe),
    .first_bus_data_pin_i     (sda),
    .first_bus_data_pin_o     (),
    .first_bus_data_pin_oe_o  (sda_oe),
    .boot_cfg_o               (boot_cfg),
    .boot_done_o              (boot_done)
  );

  ibr_eeprom
  #(
    .DEV_ADDR   (7'h50),
    .FIRST_BYTE (8'hA5)
  )
  eeprom
  (
    .scl_i    (scl),
    .sda_i    (sda),
    .sda_oe_o (ee_oe)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Verdict and end of run
  task automatic close_out();
    $display("Checks: %0d  mismatches: %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Classic cycle held until ack; read data taken at that edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= wr;
    adr   <= a;
    dat_w <= d;
    sel   <= s;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rd_q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  // Straps held steady across the capture edge after release
  task automatic restart(input logic s, input logic [1:0] b);
    @(posedge clk);
    sec  <= s;
    boot <= b;
    rst  <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  // Clock cycles between two rises of the bus clock
  task automatic measure();
    while (scl !== 1'b0) @(posedge clk);
    while (scl !== 1'b1) @(posedge clk);
    period = 0;
    while (scl !== 1'b0)
    begin
      @(posedge clk);
      period++;
    end
    while (scl !== 1'b1)
    begin
      @(posedge clk);
      period++;
    end
  endtask

  // Polls status until the transfer has finished
  task automatic wait_idle();
    do
      rd(IBR_STAT_OFS);
    while (rd_q[IBR_STAT_BUSY] !== 1'b0);
  endtask

  // ****************************************************************
  // Clock, watchdog and scenarios
  // ****************************************************************
  always #50 clk = ~clk;

  // A hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fail_count++;
      close_out();
    end
  end

  // Boot run, software read, then rate table over nacked addresses
  initial
  begin
    restart(1'b1, 2'b10);
    rd(IBR_DIV_OFS);
    `IBR_CHK(rd_q, 32'h0)
    rd(8'h10);
    `IBR_CHK(rd_q, 32'h0)
    bus(1'b1, IBR_DIV_OFS, 32'h3F, 4'h0);
    rd(IBR_DIV_OFS);
    `IBR_CHK(rd_q, 32'h0)
    bus(1'b1, IBR_DIV_OFS, 32'h20, 4'hF);
    rd(IBR_DIV_OFS);
    `IBR_CHK(rd_q, 32'h20)
    measure();
    `IBR_CHK(period, 3840)
    while (boot_done !== 1'b1)
      @(posedge clk);
    `IBR_CHK(boot_cfg, 8'hA5)
    rd(IBR_STAT_OFS);
    `IBR_CHK(rd_q, 32'h2)
    restart(1'b0, 2'b00);
    // Far ends of the table, seen by the design's own table checks
    bus(1'b1, IBR_DIV_OFS, 32'h1F, 4'hF);
    rd(IBR_DIV_OFS);
    `IBR_CHK(rd_q, 32'h1F)
    bus(1'b1, IBR_DIV_OFS, 32'h3F, 4'hF);
    rd(IBR_DIV_OFS);
    `IBR_CHK(rd_q, 32'h3F)
    bus(1'b1, IBR_DIV_OFS, 32'h20, 4'hF);
    bus(1'b1, IBR_CTL_OFS, {24'h0, 7'h50, 1'b1}, 4'hF);
    measure();
    `IBR_CHK(period, 2 * 256)
    bus(1'b1, IBR_DIV_OFS, 32'h00, 4'hF);
    measure();
    measure();
    `IBR_CHK(period, 2 * 384)
    // Back to the fast code to keep the run short
    bus(1'b1, IBR_DIV_OFS, 32'h20, 4'hF);
    wait_idle();
    rd(IBR_DATA_OFS);
    `IBR_CHK(rd_q, 32'h0)
    rd(IBR_DATA_OFS);
    `IBR_CHK(rd_q, 32'hA6)
    // Wrong address keeps the EEPROM off the line across resets
    for (int i = 0; i < 3; i++)
    begin
      restart(PRES[i] == 3, 2'b00);
      bus(1'b1, IBR_DIV_OFS, {26'h0, CODES[i]}, 4'hF);
      bus(1'b1, IBR_CTL_OFS, {24'h0, 7'h51, 1'b1}, 4'hF);
      measure();
      `IBR_CHK(period, PRES[i] * DIVS[i])
    end
    wait_idle();
    `IBR_CHK(rd_q, 32'h4)
    bus(1'b1, IBR_STAT_OFS, 32'h4, 4'hF);
    rd(IBR_STAT_OFS);
    `IBR_CHK(rd_q, 32'h0)
    close_out();
  end
endmodule
